// >>> common/ee_regs.svh
`ifndef EE_REGS_SVH
`define EE_REGS_SVH

// Register byte offsets
`define CTRL_OFS      12'h000
`define STATUS_OFS    12'h004

// Control register fields and reset value
`define CTRL_FOUR_BIT 0
`define CTRL_SWWP_BIT 1
`define CTRL_RST      32'h00000001

// Status register fields
`define STAT_BUSY_BIT 0
`define STAT_WP_BIT   1
`define STAT_PEND_BIT 2
`define STAT_PTR_LSB  16

// Control byte type code and page size
`define TYPE_CODE     4'ha
`define PAGE_BYTES    16

// Write cycle time and clock rate
`define WC_TIME_MS    5
`define CLK_HZ        20000000

`endif

// >>> common/ee_pkg.sv
package ee_pkg;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_CTRL,
    PH_ADDR,
    PH_WDATA,
    PH_RDATA
  } phase_t;

endpackage : ee_pkg

// >>> verilog/ee_slave.sv
// Contract
// - SDA fall while SCL high is START.
// - SDA rise while SCL high is STOP.
// - SDA changes only while SCL low.
// - Acknowledge holds SDA low through high.
// - No acknowledge during internal programming.
// - Release SDA after unacknowledged read byte.
// - Control byte: type, block bits, direction.
// - Block bits are upper address bits.
// - Acknowledge control only for type 1010.
// - Write: address byte, then data, acknowledged.
// - STOP after write data starts programming.
// - Buffer up to 16 bytes until STOP.
// - Only low four pointer bits increment.
// - Keep newest 16 bytes, oldest overwritten.
// - Polling: no acknowledge while still busy.
// - Write protect inhibits all programming.
// - Read sends byte at counter address.
// - Unacknowledged read byte ends transmission.
// - Repeated START aborts write, keeps pointer.
// - Acknowledged read sends next sequential byte.
// - Programming completes within 5 ms.
// - Reads ignore write protect.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "ee_regs.svh"

module ee_slave #(
  parameter int unsigned ADDR_W    = 10,
  parameter int unsigned WC_CYCLES = `WC_TIME_MS * (`CLK_HZ / 1000)
) (
  input  wire logic        mclk_i,    // System clock
  input  wire logic        rst_n_i,   // Synchronous reset
  input  wire logic        scl_i,     // Bus clock pin
  input  wire logic        sda_i,     // Bus data pin level
  output logic             sda_o,     // Data pin drive value
  output logic             sda_oe_n_o,// Data drive enable
  input  wire logic        wp_i,      // Write protect pin
  input  wire logic [11:0] paddr,     // APB address
  input  wire logic        psel,      // APB select
  input  wire logic        penable,   // APB enable
  input  wire logic        pwrite,    // APB direction
  input  wire logic [31:0] pwdata,    // APB write data
  output logic [31:0]      prdata,    // APB read data
  output logic             pready,    // APB ready
  output logic             pslverr    // APB error
);

  localparam int unsigned TMR_W = $clog2(WC_CYCLES + 1);
  localparam int unsigned DEPTH = 1 << ADDR_W;
  localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(WC_CYCLES - 1);

  typedef struct packed {
    ee_pkg::phase_t    phase;
    logic              scl_s1;
    logic              scl_s2;
    logic              scl_d;
    logic              sda_s1;
    logic              sda_s2;
    logic              sda_d;
    logic              wp_s1;
    logic              wp_s2;
    logic [3:0]        bitc;
    logic              bit_open;
    logic [7:0]        shreg;
    logic              rw;
    logic [1:0]        blk;
    logic [ADDR_W-1:0] ptr;
    logic              sda_oe_n;
    logic              mack;
    logic              pending;
    logic [15:0][7:0]  pbuf;
    logic [15:0]       pmask;
    logic [ADDR_W-5:0] page;
    logic              busy;
    logic [TMR_W-1:0]  timer;
    logic [4:0]        cidx;
    logic              four_blk;
    logic              sw_wp;
    logic [31:0]       prdata;
  } state_t;

  localparam state_t ST_RST = '{
    phase:    ee_pkg::PH_IDLE,
    scl_s1:   1'b1,
    scl_s2:   1'b1,
    scl_d:    1'b1,
    sda_s1:   1'b1,
    sda_s2:   1'b1,
    sda_d:    1'b1,
    sda_oe_n: 1'b1,
    four_blk: 1'(`CTRL_RST),
    default:  '0
  };

  state_t s;
  state_t next_s;

  logic [7:0] mem [DEPTH];

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic cond_ev;
  logic wp_eff;
  logic mem_we;
  logic apb_acc;
  logic apb_setup;
  logic map_hit;

  //////////////////////////////////////////////////////////////////////////////
  // Address helpers

  function automatic logic [ADDR_W-1:0] fit_addr(input logic [ADDR_W-1:0] a,
                                                 input logic four);
    logic [ADDR_W-1:0] r;
    r = a;
    if (!four)
    begin
      r[ADDR_W-1] = 1'b0;
    end
    return r;
  endfunction : fit_addr

  function automatic logic [ADDR_W-1:0] inc_addr(input logic [ADDR_W-1:0] a,
                                                 input logic four);
    return fit_addr(a + ADDR_W'(1), four);
  endfunction : inc_addr

  //////////////////////////////////////////////////////////////////////////////
  // Bus conditions from synchronised pins

  assign scl_rise = s.scl_s2 & ~s.scl_d;
  assign scl_fall = ~s.scl_s2 & s.scl_d;
  assign start_ev = s.scl_s2 & s.scl_d & s.sda_d & ~s.sda_s2;
  assign stop_ev  = s.scl_s2 & s.scl_d & ~s.sda_d & s.sda_s2;
  assign cond_ev  = start_ev | stop_ev;
  assign wp_eff   = s.wp_s2 | s.sw_wp;
  assign mem_we   = s.busy & ~s.cidx[4] & s.pmask[s.cidx[3:0]];

  assign apb_setup = psel & ~penable;
  assign apb_acc   = psel & penable;
  assign map_hit   = (paddr == `CTRL_OFS) || (paddr == `STATUS_OFS);

  assign sda_o      = 1'b0;
  assign sda_oe_n_o = s.sda_oe_n;
  assign prdata     = s.prdata;
  assign pready     = 1'b1;
  assign pslverr    = apb_acc & ~map_hit;

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    next_s = s;
    next_s.scl_s1 = scl_i;
    next_s.scl_s2 = s.scl_s1;
    next_s.scl_d  = s.scl_s2;
    next_s.sda_s1 = sda_i;
    next_s.sda_s2 = s.sda_s1;
    next_s.sda_d  = s.sda_s2;
    next_s.wp_s1  = wp_i;
    next_s.wp_s2  = s.wp_s1;

    // Internal write cycle: commit buffer while the cycle timer counts down
    if (s.busy)
    begin
      if (!s.cidx[4])
      begin
        next_s.cidx = s.cidx + 5'h01;
      end
      if (s.timer == '0)
      begin
        next_s.busy  = 1'b0;
        next_s.pmask = '0;
      end
      else
      begin
        next_s.timer = s.timer - TMR_W'(1);
      end
    end

    if (start_ev)
    begin
      next_s.phase    = ee_pkg::PH_CTRL;
      next_s.bitc     = 4'h0;
      next_s.bit_open = 1'b0;
      next_s.sda_oe_n = 1'b1;
      if (!s.busy)
      begin
        next_s.pmask = '0;
      end
      next_s.pending = 1'b0;
    end
    else if (stop_ev)
    begin
      next_s.phase    = ee_pkg::PH_IDLE;
      next_s.bitc     = 4'h0;
      next_s.sda_oe_n = 1'b1;
      next_s.pending  = 1'b0;
      if (s.pending && !s.busy && !wp_eff)
      begin
        next_s.busy  = 1'b1;
        next_s.timer = TMR_LOAD;
        next_s.cidx  = 5'h00;
        next_s.page  = s.ptr[ADDR_W-1:4];
      end
      else if (!s.busy)
      begin
        next_s.pmask = '0;
      end
    end
    else if (s.phase != ee_pkg::PH_IDLE)
    begin
      if (scl_rise)
      begin
        next_s.bit_open = 1'b1;
        if (s.bitc < 4'h8)
        begin
          if (s.phase != ee_pkg::PH_RDATA)
          begin
            next_s.shreg = {s.shreg[6:0], s.sda_s2};
          end
        end
        else if (s.phase == ee_pkg::PH_RDATA)
        begin
          next_s.mack = ~s.sda_s2;
        end
      end
      // The clock fall that closes a START carries no bit
      else if (scl_fall && s.bit_open)
      begin
        if (s.phase == ee_pkg::PH_RDATA)
        begin
          if (s.bitc < 4'h7)
          begin
            next_s.shreg    = {s.shreg[6:0], 1'b0};
            next_s.sda_oe_n = s.shreg[6];
            next_s.bitc     = s.bitc + 4'h1;
          end
          else if (s.bitc == 4'h7)
          begin
            next_s.sda_oe_n = 1'b1;
            next_s.bitc     = 4'h8;
          end
          else if (s.mack)
          begin
            next_s.shreg    = mem[s.ptr];
            next_s.sda_oe_n = mem[s.ptr][7];
            next_s.ptr      = inc_addr(s.ptr, s.four_blk);
            next_s.bitc     = 4'h0;
          end
          else
          begin
            next_s.phase = ee_pkg::PH_IDLE;
            next_s.bitc  = 4'h0;
          end
        end
        else if (s.bitc < 4'h7)
        begin
          next_s.bitc = s.bitc + 4'h1;
        end
        else if (s.bitc == 4'h7)
        begin
          next_s.bitc = 4'h8;
          case (s.phase)
            ee_pkg::PH_CTRL:
            begin
              if (s.shreg[7:4] == `TYPE_CODE && !s.busy)
              begin
                next_s.sda_oe_n = 1'b0;
                next_s.rw       = s.shreg[0];
                next_s.blk      = s.shreg[2:1];
              end
              else
              begin
                next_s.phase = ee_pkg::PH_IDLE;
                next_s.bitc  = 4'h0;
              end
            end
            ee_pkg::PH_ADDR:
            begin
              next_s.sda_oe_n = 1'b0;
              next_s.ptr = fit_addr({s.blk, s.shreg}, s.four_blk);
            end
            ee_pkg::PH_WDATA:
            begin
              next_s.sda_oe_n = 1'b0;
              next_s.pbuf[s.ptr[3:0]]  = s.shreg;
              next_s.pmask[s.ptr[3:0]] = 1'b1;
              next_s.ptr[3:0] = s.ptr[3:0] + 4'h1;
              next_s.pending  = 1'b1;
            end
            default:
            begin
              next_s.phase = ee_pkg::PH_IDLE;
            end
          endcase
        end
        else
        begin
          next_s.sda_oe_n = 1'b1;
          next_s.bitc     = 4'h0;
          case (s.phase)
            ee_pkg::PH_CTRL:
            begin
              if (s.rw)
              begin
                next_s.phase    = ee_pkg::PH_RDATA;
                next_s.shreg    = mem[s.ptr];
                next_s.sda_oe_n = mem[s.ptr][7];
                next_s.ptr      = inc_addr(s.ptr, s.four_blk);
              end
              else
              begin
                next_s.phase = ee_pkg::PH_ADDR;
              end
            end
            ee_pkg::PH_ADDR:
            begin
              next_s.phase = ee_pkg::PH_WDATA;
            end
            default:
            begin
              next_s.phase = s.phase;
            end
          endcase
        end
      end
    end

    // APB slave, zero wait states
    if (apb_setup && !pwrite)
    begin
      next_s.prdata = 32'h00000000;
      if (paddr == `CTRL_OFS)
      begin
        next_s.prdata[`CTRL_FOUR_BIT] = s.four_blk;
        next_s.prdata[`CTRL_SWWP_BIT] = s.sw_wp;
      end
      else if (paddr == `STATUS_OFS)
      begin
        next_s.prdata[`STAT_BUSY_BIT] = s.busy;
        next_s.prdata[`STAT_WP_BIT]   = wp_eff;
        next_s.prdata[`STAT_PEND_BIT] = s.pending;
        next_s.prdata[`STAT_PTR_LSB +: ADDR_W] = s.ptr;
      end
    end
    if (apb_acc && pwrite && paddr == `CTRL_OFS)
    begin
      next_s.four_blk = pwdata[`CTRL_FOUR_BIT];
      next_s.sw_wp    = pwdata[`CTRL_SWWP_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State and array

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      s <= ST_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (mem_we)
    begin
      mem[{s.page, s.cidx[3:0]}] <= s.pbuf[s.cidx[3:0]];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk_i);
  endclocking

  default disable iff (!rst_n_i);

  sequence s_wc_begin;
    !s.busy ##1 s.busy;
  endsequence

  sequence s_ctrl_match;
    scl_fall && !cond_ev && s.phase == ee_pkg::PH_CTRL && s.bitc == 4'h7
      && s.shreg[7:4] == `TYPE_CODE && !s.busy;
  endsequence

  a_busy_no_ack: assert property (
    s.busy && s.phase == ee_pkg::PH_CTRL |-> s.sda_oe_n)
    else $error("acknowledge driven while programming");

  a_start_rearm: assert property (
    start_ev |=> s.phase == ee_pkg::PH_CTRL && s.bitc == 4'h0)
    else $error("start did not rearm receiver");

  a_stop_idle: assert property (
    stop_ev |=> s.phase == ee_pkg::PH_IDLE && s.sda_oe_n)
    else $error("stop did not idle the slave");

  a_ctrl_ack: assert property (
    s_ctrl_match |=> !s.sda_oe_n)
    else $error("matching control byte not acknowledged");

  a_wc_start: assert property (
    stop_ev && s.pending && !s.busy && !wp_eff |=> s.busy)
    else $error("stop after data did not start programming");

  a_wp_inhibit: assert property (
    stop_ev && wp_eff && !s.busy |=> !s.busy ##1 !mem_we)
    else $error("programming started under write protect");

  a_page_wrap: assert property (
    scl_fall && !cond_ev && s.phase == ee_pkg::PH_WDATA && s.bitc == 4'h7
    |=> s.ptr[ADDR_W-1:4] == $past(s.ptr[ADDR_W-1:4])
        && s.ptr[3:0] == $past(s.ptr[3:0]) + 4'h1)
    else $error("page pointer did not wrap in page");

  a_sda_scl_low: assert property (
    $changed(s.sda_oe_n) && !$past(cond_ev) |-> !$past(s.scl_s2))
    else $error("data drive changed while clock high");

  a_wc_length: assert property (
    s_wc_begin |-> s.timer == TMR_LOAD)
    else $error("write cycle timer loaded wrongly");

  a_wc_end: assert property (
    s.busy && s.timer == '0 |=> !s.busy)
    else $error("write cycle overran its time");

endmodule : ee_slave

// >>> sim/i2c_mst.sv
`timescale 1ns/1ps

module i2c_mst (
  input  wire logic sda_i,    // Resolved data line
  output logic      scl_o,    // Bus clock
  output logic      sda_dn_o  // High pulls data low
);

  initial
  begin
    scl_o = 1'b1;
    sda_dn_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One clock pulse; data changes only while the clock is low
  task automatic bit_x(input logic b, output logic s);
    scl_o = 1'b0;
    #100 sda_dn_o = ~b;
    #100 scl_o = 1'b1;
    #100 s = sda_i;
    #100 scl_o = 1'b0;
  endtask : bit_x

  task automatic start;
    // Move pin changes off the 50 ns system clock's rising edges
    if ($time % 50 != 0)
      #(50 - $time % 50);
    if (!scl_o)
    begin
      #100 sda_dn_o = 1'b0;
      #100 scl_o = 1'b1;
    end
    #200 sda_dn_o = 1'b1;
    #200 scl_o = 1'b0;
  endtask : start

  task automatic stop;
    #100 sda_dn_o = 1'b1;
    #100 scl_o = 1'b1;
    #200 sda_dn_o = 1'b0;
    #200;
  endtask : stop

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], s);
    bit_x(1'b1, s);
    ack = ~s;
  endtask : wr_byte

  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_x(1'b1, d[i]);
    bit_x(~mack, s);
  endtask : rd_byte

endmodule : i2c_mst

// >>> sim/testbench.sv
`timescale 1ns/1ps
`include "ee_regs.svh"

module testbench;

  typedef struct packed {
    logic [2:0] wb;
    logic [2:0] rb;
    logic [7:0] wa;
    logic [7:0] d;
  } row_t;

  logic        mclk_i;
  logic        rst_n_i;
  logic        wp_i;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        sda_o;
  logic        sda_oe_n_o;
  logic        scl;
  logic        sda_dn;
  logic        sda_w;
  logic        a;
  logic        er;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rv;
  logic [7:0]  d;
  int          errors;
  int          total_checks;
  int          cyc;
  row_t        rows [4];

  // Pull-up on the data line, either party may pull it low
  assign sda_w = sda_dn ? 1'b0 : (sda_oe_n_o ? 1'b1 : sda_o);

  ee_slave #(.WC_CYCLES(200)) ee_slave_inst (
    .mclk_i     (mclk_i),
    .rst_n_i    (rst_n_i),
    .scl_i      (scl),
    .sda_i      (sda_w),
    .sda_o      (sda_o),
    .sda_oe_n_o (sda_oe_n_o),
    .wp_i       (wp_i),
    .paddr      (paddr),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr)
  );

  i2c_mst i2c_mst_inst (
    .sda_i    (sda_w),
    .scl_o    (scl),
    .sda_dn_o (sda_dn)
  );

  initial
  begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      errors++;
      give_verdict();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge mclk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge mclk_i);
    penable <= 1'b1;
    do
      @(posedge mclk_i);
    while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic sendb(input logic [7:0] b, input logic e);
    i2c_mst_inst.wr_byte(b, a);
    chk("ack", {31'h0, e}, {31'h0, a});
  endtask : sendb

  task automatic setptr(input logic [2:0] b, input logic [7:0] wa);
    i2c_mst_inst.start();
    sendb({`TYPE_CODE, b, 1'b0}, 1'b1);
    sendb(wa, 1'b1);
  endtask : setptr

  task automatic rd_ctrl(input logic [2:0] b);
    i2c_mst_inst.start();
    sendb({`TYPE_CODE, b, 1'b1}, 1'b1);
  endtask : rd_ctrl

  task automatic rdchk(input logic [2:0] b, input logic [7:0] wa, input logic [7:0] e);
    setptr(b, wa);
    rd_ctrl(b);
    i2c_mst_inst.rd_byte(1'b0, d);
    chk("rd", {24'h0, e}, {24'h0, d});
    i2c_mst_inst.stop();
  endtask : rdchk

  task automatic wrpage(input logic [2:0] b, input logic [7:0] wa, input int n,
                        input logic [7:0] d0);
    setptr(b, wa);
    for (int i = 0; i < n; i++)
      sendb(d0 + 8'(i), 1'b1);
    i2c_mst_inst.stop();
    i2c_mst_inst.start();
    sendb({`TYPE_CODE, b, 1'b0}, wp_i);
    i2c_mst_inst.stop();
    for (int i = 0; i < 20 && a !== 1'b1; i++)
    begin
      i2c_mst_inst.start();
      i2c_mst_inst.wr_byte({`TYPE_CODE, b, 1'b0}, a);
      i2c_mst_inst.stop();
    end
    chk("done", 32'h1, {31'h0, a});
  endtask : wrpage

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n_i = 1'b0;
    wp_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    errors = 0;
    total_checks = 0;
    cyc = 0;
    rows[0] = '{3'b000, 3'b000, 8'h05, 8'ha5};
    rows[1] = '{3'b101, 3'b001, 8'h40, 8'h3c};
    rows[2] = '{3'b011, 3'b111, 8'hff, 8'h5a};
    rows[3] = '{3'b010, 3'b010, 8'h40, 8'hc3};
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    apb(1'b0, `CTRL_OFS, 32'h0);
    chk("ctrl", `CTRL_RST, rv);
    apb(1'b0, `STATUS_OFS, 32'h0);
    chk("status", 32'h0, rv);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    foreach (rows[i])
    begin
      wrpage(rows[i].wb, rows[i].wa, 1, rows[i].d);
      rdchk(rows[i].rb, rows[i].wa, rows[i].d);
    end
    rdchk(3'b001, 8'h40, 8'h3c);
    // Seventeen bytes from 1e wrap inside the page
    wrpage(3'b000, 8'h1e, 17, 8'h00);
    setptr(3'b000, 8'h1e);
    rd_ctrl(3'b000);
    i2c_mst_inst.rd_byte(1'b1, d);
    chk("wrap", 32'h10, {24'h0, d});
    i2c_mst_inst.rd_byte(1'b0, d);
    chk("seq", 32'h01, {24'h0, d});
    i2c_mst_inst.stop();
    rdchk(3'b000, 8'h10, 8'h02);
    apb(1'b0, `STATUS_OFS, 32'h0);
    chk("ptr", 32'h00110000, rv);
    rd_ctrl(3'b000);
    i2c_mst_inst.rd_byte(1'b0, d);
    chk("cur", 32'h03, {24'h0, d});
    i2c_mst_inst.stop();
    i2c_mst_inst.start();
    sendb(8'hb0, 1'b0);
    i2c_mst_inst.stop();
    @(posedge mclk_i);
    wp_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    wrpage(3'b000, 8'h05, 1, 8'hff);
    rdchk(3'b000, 8'h05, 8'ha5);
    @(posedge mclk_i);
    wp_i <= 1'b0;
    apb(1'b1, `CTRL_OFS, 32'h0);
    wrpage(3'b010, 8'h77, 1, 8'h99);
    rdchk(3'b000, 8'h77, 8'h99);
    give_verdict();
  end

endmodule : testbench
